// >>> design/gpio_cfg.svh
/*
 * Constants of the banked GPIO controller: sizes, register map, responses
 * and input timing. Assumes it is included by bare name, possibly twice.
 */
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
`define GPIO_PINS 104
`define GPIO_BANK_W 16
`define GPIO_PIN_IRQS 10
`define GPIO_AW 12
`define GPIO_KIND_DIR 3'h0
`define GPIO_KIND_OUT 3'h1
`define GPIO_KIND_SET 3'h2
`define GPIO_KIND_CLR 3'h3
`define GPIO_KIND_IN 3'h4
`define GPIO_KIND_RISE 3'h5
`define GPIO_KIND_FALL 3'h6
`define GPIO_OFS_STAT 12'h100
`define GPIO_OFS_MASK 12'h104
`define GPIO_GLOB_BIT 8
`define GPIO_KIND_LSB 5
`define GPIO_BANK_LSB 2
`define GPIO_RESP_OKAY 2'h0
`define GPIO_RESP_SLVERR 2'h2
`define GPIO_CLK_NS 4
`define GPIO_MIN_PULSE_NS 52
`define GPIO_SYNC_STAGES 2
`endif

// >>> design/gpio_pkg.sv
/*
 * Types and shared helpers of the banked GPIO controller.
 * Assumes gpio_cfg.svh is on the include path.
 */
`include "gpio_cfg.svh"
`default_nettype none
package gpio_pkg;

	typedef struct packed {
		logic hit;
		logic stat;
		logic mask;
		logic [2:0] kind;
		logic [2:0] bank;
	} reg_dec_t;

	typedef struct packed {
		logic [`GPIO_AW-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} wr_req_t;

	// Unused word offsets and the top bank slot answer as unmapped
	function automatic reg_dec_t decode(input logic [`GPIO_AW-1:0] a,
		input logic [3:0] nbank);
		reg_dec_t d;
		d = '0;
		d.kind = a[`GPIO_KIND_LSB +: 3];
		d.bank = a[`GPIO_BANK_LSB +: 3];
		d.stat = (a == `GPIO_OFS_STAT);
		d.mask = (a == `GPIO_OFS_MASK);
		d.hit = d.stat | d.mask |
			((a[`GPIO_AW-1:`GPIO_GLOB_BIT] == '0) && (a[1:0] == '0) &&
			(d.kind <= `GPIO_KIND_FALL) && ({1'b0, d.bank} < nbank));
		return d;
	endfunction

	function automatic logic [31:0] strb_bits(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

endpackage
`default_nettype wire

// >>> design/pin_sync.sv
/*
 * Two-flop synchroniser for asynchronous pin levels.
 * Assumes one clock and a synchronous active-low reset.
 */
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] stab_q;

	if (W < 1) begin : g_chk
		$error("pin_sync: W must be at least 1");
	end

	// Only the second stage reads the first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			stab_q <= '0;
		end else begin
			meta_q <= d;
			stab_q <= meta_q;
		end
	end

	assign q = stab_q;

endmodule
`default_nettype wire

// >>> design/bank_edge_detect.sv
/*
 * Per-pin edge detector with separate rising and falling enables.
 * Assumes lvl is already synchronised to aclk.
 */
`default_nettype none
module bank_edge_detect #(
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] lvl,
	input wire logic [W-1:0] rise_en,
	input wire logic [W-1:0] fall_en,
	output logic [W-1:0] evt
);

	logic [W-1:0] prev_q;

	if (W < 1) begin : g_chk
		$error("bank_edge_detect: W must be at least 1");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= lvl;
		end
	end

	// Both enables set gives an event on either edge
	assign evt = (rise_en & lvl & ~prev_q) | (fall_en & ~lvl & prev_q);

endmodule
`default_nettype wire

// >>> design/banked_gpio_controller.sv
/*
 * Banked GPIO controller: direction, output, set/clear, input and edge
 * registers per bank of sixteen pins, pin and bank interrupts and DMA
 * events, one summary interrupt, all behind an AXI4-Lite slave.
 * Assumes pins arrive asynchronously and one clock drives everything.
 */
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`include "gpio_cfg.svh"
`default_nettype none
module banked_gpio_controller
	import gpio_pkg::*;
#(
	parameter int NPIN = `GPIO_PINS,
	parameter int NBANK = (NPIN + `GPIO_BANK_W - 1) / `GPIO_BANK_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`GPIO_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`GPIO_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NPIN-1:0] pin_input_level,
	output logic [NPIN-1:0] pin_output_level,
	output logic [NPIN-1:0] pin_output_enable,
	output logic [`GPIO_PIN_IRQS-1:0] pin_irq,
	output logic [NBANK-1:0] bank_irq,
	output logic [`GPIO_PIN_IRQS-1:0] pin_dma_event,
	output logic [NBANK-1:0] bank_dma_event,
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	// Sizes and checks

	localparam int BW = `GPIO_BANK_W;
	localparam int W = NBANK * BW;
	localparam int NPI = `GPIO_PIN_IRQS;
	localparam int NEV = NPI + NBANK;
	localparam int PULSE_NS = `GPIO_MIN_PULSE_NS;
	localparam int PULSE_CYC =
		(PULSE_NS + `GPIO_CLK_NS - 1) / `GPIO_CLK_NS;
	localparam logic [3:0] NB4 = 4'(NBANK);
	// Unpopulated bits of the last bank stay zero
	localparam logic [W-1:0] POP = ~({W{1'b1}} << NPIN);

	if (NPIN < NPI || NBANK > 7 || W < NPIN || W - BW >= NPIN)
	begin : g_size_chk
		$error("banked_gpio_controller: unsupported NPIN or NBANK");
	end

	// A legal pulse must last at least one clock cycle
	if (PULSE_CYC < 1) begin : g_pulse_chk
		$error("banked_gpio_controller: clock too slow for pulses");
	end

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [W-1:0] merge(input logic [W-1:0] old,
		input logic [W-1:0] sel, input logic [W-1:0] val);
		return (old & ~sel) | (val & sel);
	endfunction

	function automatic logic [BW-1:0] pick(input logic [W-1:0] v,
		input logic [2:0] bank);
		return BW'(v >> (BW * int'(bank)));
	endfunction

	function automatic logic [W-1:0] place(input logic [BW-1:0] v,
		input logic [2:0] bank);
		return (W'(v) << (BW * int'(bank))) & POP;
	endfunction

	////////////////////////////////////////////////////////////////////
	// State

	logic [W-1:0] dir_q;
	logic [W-1:0] out_q;
	logic [W-1:0] rise_q;
	logic [W-1:0] fall_q;
	logic [W-1:0] dir_d;
	logic [W-1:0] out_d;
	logic [W-1:0] rise_d;
	logic [W-1:0] fall_d;
	logic [NEV-1:0] stat_q;
	logic [NEV-1:0] mask_q;
	logic [NEV-1:0] stat_d;
	logic [NEV-1:0] mask_d;
	logic irq_q;
	logic [NPI-1:0] pin_irq_q;
	logic [NPI-1:0] pin_dma_q;
	logic [NBANK-1:0] bank_irq_q;
	logic [NBANK-1:0] bank_dma_q;

	wr_req_t req_q;
	logic aw_have_q;
	logic w_have_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	logic [NPIN-1:0] in_lvl;
	logic [W-1:0] evt;
	logic [NBANK-1:0] bank_evt;

	////////////////////////////////////////////////////////////////////
	// Pin input path

	pin_sync #(
		.W(NPIN)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(pin_input_level),
		.q(in_lvl)
	);

	wire [W-1:0] in_w = W'(in_lvl);

	bank_edge_detect #(
		.W(W)
	) u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.lvl(in_w),
		.rise_en(rise_q),
		.fall_en(fall_q),
		.evt(evt)
	);

	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		assign bank_evt[b] = |evt[b*BW +: BW];
	end

	// Pin events in the low bits, bank events above
	wire [NEV-1:0] ev_all = {bank_evt, evt[NPI-1:0]};

	////////////////////////////////////////////////////////////////////
	// Write channel

	wire aw_hs = s_axi_awvalid & awready_q;
	wire w_hs = s_axi_wvalid & wready_q;
	wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
	wire aw_have_d = aw_hs | (aw_have_q & ~wr_go);
	wire w_have_d = w_hs | (w_have_q & ~wr_go);
	wire bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);

	wire reg_dec_t wdec = decode(req_q.addr, NB4);
	wire wr_ok = wr_go & wdec.hit;
	wire wr_bank = wr_ok & ~wdec.stat & ~wdec.mask;
	wire [31:0] wmask = strb_bits(req_q.strb);
	wire [31:0] wbits = wmask & req_q.data;
	wire [W-1:0] wsel = place(wmask[BW-1:0], wdec.bank);
	wire [W-1:0] wval = place(req_q.data[BW-1:0], wdec.bank);
	wire [W-1:0] w1 = wsel & wval;

	wire do_dir = wr_bank & (wdec.kind == `GPIO_KIND_DIR);
	wire do_out = wr_bank & (wdec.kind == `GPIO_KIND_OUT);
	wire do_set = wr_bank & (wdec.kind == `GPIO_KIND_SET);
	wire do_clr = wr_bank & (wdec.kind == `GPIO_KIND_CLR);
	wire do_rise = wr_bank & (wdec.kind == `GPIO_KIND_RISE);
	wire do_fall = wr_bank & (wdec.kind == `GPIO_KIND_FALL);
	wire do_stat = wr_ok & wdec.stat;
	wire do_mask = wr_ok & wdec.mask;

	assign dir_d = do_dir ? merge(dir_q, wsel, wval) : dir_q;
	// Set and clear touch only the ones; zeros leave other pins alone
	assign out_d = do_out ? merge(out_q, wsel, wval) :
		do_set ? (out_q | w1) :
		do_clr ? (out_q & ~w1) :
		out_q;
	assign rise_d = do_rise ? merge(rise_q, wsel, wval) : rise_q;
	assign fall_d = do_fall ? merge(fall_q, wsel, wval) : fall_q;
	// A new event in the clearing cycle survives the clear
	assign stat_d = (stat_q & ~(do_stat ? wbits[NEV-1:0] : '0)) | ev_all;
	assign mask_d = do_mask ?
		((mask_q & ~wmask[NEV-1:0]) | wbits[NEV-1:0]) :
		mask_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= ~aw_have_d;
			wready_q <= ~w_have_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_q <= '0;
		end else begin
			if (aw_hs) begin
				req_q.addr <= s_axi_awaddr;
			end
			if (w_hs) begin
				req_q.data <= s_axi_wdata;
				req_q.strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `GPIO_RESP_OKAY;
		end else begin
			bvalid_q <= bvalid_d;
			if (wr_go) begin
				bresp_q <= wdec.hit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel

	wire ar_hs = s_axi_arvalid & arready_q;
	wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
	wire reg_dec_t rdec = decode(s_axi_araddr, NB4);
	wire [2:0] rk = rdec.kind;
	wire [2:0] rb = rdec.bank;

	// Set and clear read back the held drive values
	wire rd_out = (rk == `GPIO_KIND_OUT) | (rk == `GPIO_KIND_SET) |
		(rk == `GPIO_KIND_CLR);
	wire [BW-1:0] rd_bank =
		(rk == `GPIO_KIND_DIR) ? pick(dir_q, rb) :
		rd_out ? pick(out_q, rb) :
		(rk == `GPIO_KIND_IN) ? pick(in_w, rb) :
		(rk == `GPIO_KIND_RISE) ? pick(rise_q, rb) :
		pick(fall_q, rb);
	wire [31:0] rd_word =
		!rdec.hit ? '0 :
		rdec.stat ? 32'(stat_q) :
		rdec.mask ? 32'(mask_q) :
		32'(rd_bank);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_q <= '0;
			rresp_q <= `GPIO_RESP_OKAY;
		end else if (ar_hs) begin
			rdata_q <= rd_word;
			rresp_q <= rdec.hit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin control registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_q <= '0;
			out_q <= '0;
		end else begin
			dir_q <= dir_d;
			out_q <= out_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rise_q <= '0;
			fall_q <= '0;
		end else begin
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Events and interrupts

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= |(stat_d & mask_d);
		end
	end

	// Pin outputs pulse one cycle per detected edge; bank outputs pulse for any edge in their bank
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_irq_q <= '0;
			pin_dma_q <= '0;
			bank_irq_q <= '0;
			bank_dma_q <= '0;
		end else begin
			pin_irq_q <= evt[NPI-1:0];
			pin_dma_q <= evt[NPI-1:0];
			bank_irq_q <= bank_evt;
			bank_dma_q <= bank_evt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	// Level is driven whatever the direction; the enable gates the pad
	assign pin_output_level = out_q[NPIN-1:0];
	assign pin_output_enable = dir_q[NPIN-1:0];
	assign pin_irq = pin_irq_q;
	assign pin_dma_event = pin_dma_q;
	assign bank_irq = bank_irq_q;
	assign bank_dma_event = bank_dma_q;
	assign irq = irq_q;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule
`default_nettype wire

// >>> tb/gpio_pin_model.sv
/* External devices on the pins: open-drain wiring with pull-ups.
 Assumes the bench sets ext_level, the level the outside wants. */
`default_nettype none
module gpio_pin_model #(
	parameter int NPIN = 104
) (
	input wire logic [NPIN-1:0] ext_level,
	input wire logic [NPIN-1:0] pin_output_level,
	input wire logic [NPIN-1:0] pin_output_enable,
	output logic [NPIN-1:0] pin_input_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// A driven low wins over the outside, so drive and level can differ
	assign pin_input_level = ext_level &
		~(pin_output_enable & ~pin_output_level);
endmodule
`default_nettype wire

// >>> tb/banked_gpio_controller_checker.sv
/* Port checker of the banked GPIO controller.
 Assumes it is bound to every controller instance. */
`default_nettype none
module banked_gpio_controller_checker #(
	parameter int NPIN = 104,
	parameter int NBANK = 7
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NPIN-1:0] pin_input_level,
	input wire logic [NPIN-1:0] pin_output_level,
	input wire logic [NPIN-1:0] pin_output_enable,
	input wire logic [9:0] pin_irq,
	input wire logic [NBANK-1:0] bank_irq,
	input wire logic [9:0] pin_dma_event,
	input wire logic [NBANK-1:0] bank_dma_event
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	// The write retires one cycle after it is taken, then bvalid rises
	sequence s_b_rises;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_wr_answer;
		s_wr_taken ##0 !s_axi_bvalid |=> s_b_rises;
	endproperty
	property p_b_hold;
		s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=>
			s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	// Drive and direction move only when a write retires
	property p_out_by_write;
		$changed(pin_output_level) |-> $rose(s_axi_bvalid);
	endproperty
	property p_oe_by_write;
		$changed(pin_output_enable) |-> $rose(s_axi_bvalid);
	endproperty
	property p_dma_pin;
		pin_dma_event == pin_irq;
	endproperty
	property p_dma_bank;
		bank_dma_event == bank_irq;
	endproperty
	property p_bank0_agg;
		|pin_irq |-> bank_irq[0];
	endproperty
	property p_pulse;
		(pin_irq & $past(pin_irq)) == '0;
	endproperty
	property p_sync;
		pin_irq[0] |->
			$past(pin_input_level[0], 3) != $past(pin_input_level[0], 4);
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("no write answer");
	a_b_hold: assert property (p_b_hold)
		else $error("bresp dropped");
	a_rd_answer: assert property (p_rd_answer)
		else $error("no read answer");
	a_r_hold: assert property (p_r_hold)
		else $error("rdata dropped");
	a_out_by_write: assert property (p_out_by_write)
		else $error("stray drive");
	a_oe_by_write: assert property (p_oe_by_write)
		else $error("stray dir");
	a_dma_pin: assert property (p_dma_pin)
		else $error("pin dma differs");
	a_dma_bank: assert property (p_dma_bank)
		else $error("bank dma differs");
	a_bank0_agg: assert property (p_bank0_agg)
		else $error("bank0 missed");
	a_pulse: assert property (p_pulse)
		else $error("pulse too long");
	a_sync: assert property (p_sync)
		else $error("edge timing off");
endmodule
bind banked_gpio_controller banked_gpio_controller_checker #(.NPIN(NPIN),
	.NBANK(NBANK)) chk_inst (.*);
`default_nettype wire

// >>> tb/test_banked_gpio_controller.sv
/* Register-level bench of the banked GPIO controller.
 Assumes the open-drain pin model and the bound checker. */
`include "gpio_cfg.svh"
`default_nettype none
module test_banked_gpio_controller;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [1:0] rsp_ok = `GPIO_RESP_OKAY;
	localparam logic [1:0] rsp_err = `GPIO_RESP_SLVERR;
	logic aclk = 0, aresetn = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [103:0] ext_level = '0, pin_input_level;
	logic [103:0] pin_output_level, pin_output_enable;
	logic [9:0] pin_irq, pin_dma_event;
	logic [6:0] bank_irq, bank_dma_event;
	int n_mismatch = 0, samples_checked = 0;
	int cnt_pin[10], cnt_bank[7];
	banked_gpio_controller banked_gpio_controller_inst (.*);
	gpio_pin_model gpio_pin_model_inst (.*);
	initial forever #2 aclk = ~aclk;
	always @(posedge aclk) begin
		foreach (cnt_pin[i]) cnt_pin[i] += pin_irq[i];
		foreach (cnt_bank[i]) cnt_bank[i] += bank_irq[i];
	end
////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Ready is raised late on purpose, so the slave must hold its answer
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		bit done;
		done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) done = 1;
			else if (s_axi_bvalid) s_axi_bready <= 1;
		end
		if (!done) begin
			n_mismatch++;
			test_done;
		end
		s_axi_bready <= 0;
		chk("bresp", r, s_axi_bresp);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		bit done;
		done = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready) done = 1;
			else if (s_axi_rvalid) s_axi_rready <= 1;
		end
		if (!done) begin
			n_mismatch++;
			test_done;
		end
		s_axi_rready <= 0;
		chk("rresp", r, s_axi_rresp);
		chk("rdata", d, s_axi_rdata);
	endtask
////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(12'h000, 32'h0, rsp_ok);
		rd(12'h0a0, 32'h0, rsp_ok);
		chk("oe", 32'h0, pin_output_enable[31:0]);
		wr(12'h000, 32'h00ff, rsp_ok);
		wr(12'h020, 32'ha5a5, rsp_ok);
		chk("oe0", 32'h00ff, {16'h0, pin_output_enable[15:0]});
		chk("out0", 32'ha5a5, {16'h0, pin_output_level[15:0]});
		ext_level[31:0] <= 32'h1234ff0f;
		repeat (20) @(posedge aclk);
		rd(12'h080, 32'hff05, rsp_ok);
		rd(12'h084, 32'h1234, rsp_ok);
		rd(12'h020, 32'ha5a5, rsp_ok);
		s_axi_wstrb <= 4'h2;
		wr(12'h020, 32'h3c00, rsp_ok);
		s_axi_wstrb <= 4'hf;
		rd(12'h020, 32'h3ca5, rsp_ok);
		wr(12'h028, 32'h00f0, rsp_ok);
		wr(12'h048, 32'h0003, rsp_ok);
		rd(12'h028, 32'h00f3, rsp_ok);
		wr(12'h068, 32'h0030, rsp_ok);
		rd(12'h048, 32'h00c3, rsp_ok);
		chk("out2", 32'h00c3, {16'h0, pin_output_level[47:32]});
		wr(12'h018, 32'hffff, rsp_ok);
		rd(12'h018, 32'h00ff, rsp_ok);
		wr(12'h01c, 32'hffff, rsp_err);
		rd(12'h01c, 32'h0, rsp_err);
		wr(12'h018, 32'h0, rsp_ok);
		wr(12'h000, 32'h0, rsp_ok);
		ext_level <= '0;
		wr(12'h0a0, 32'h0005, rsp_ok);
		wr(12'h0c0, 32'h0006, rsp_ok);
		wr(12'h0b8, 32'h0080, rsp_ok);
		repeat (20) @(posedge aclk);
		foreach (cnt_pin[i]) cnt_pin[i] = 0;
		foreach (cnt_bank[i]) cnt_bank[i] = 0;
		ext_level[3:0] <= 4'hf;
		ext_level[103] <= 1;
		repeat (16) @(posedge aclk);
		ext_level[3:0] <= 4'h0;
		ext_level[103] <= 0;
		repeat (16) @(posedge aclk);
		foreach (cnt_pin[i])
			chk("pin_irq", i == 2 ? 2 : i < 2, cnt_pin[i]);
		foreach (cnt_bank[i])
			chk("bank_irq", i == 0 ? 2 : i == 6, cnt_bank[i]);
		chk("irq", 32'h0, {31'h0, irq});
		rd(12'h100, 32'h00010407, rsp_ok);
		wr(12'h104, 32'h1, rsp_ok);
		chk("irq", 32'h1, {31'h0, irq});
		wr(12'h100, 32'h00010406, rsp_ok);
		rd(12'h100, 32'h1, rsp_ok);
		chk("irq", 32'h1, {31'h0, irq});
		wr(12'h100, 32'h1, rsp_ok);
		chk("irq", 32'h0, {31'h0, irq});
		test_done;
	end
endmodule
`default_nettype wire
